// [hw/ram_init_regs.svh]
`ifndef RAM_INIT_REGS_SVH
`define RAM_INIT_REGS_SVH

// width of one flash/ram word as moved by this client
`define RI_WORD_W        9
// most significant bit of a word, dropped in eight-bit mode
`define RI_WORD_MSB      8
// value the save bus is taken to hold after flash system reset
`define RI_WORD_RESET    9'h000
// mask that keeps the eight low data bits
`define RI_BYTE_MASK     9'h0FF
// count that ends the save wait; the synchronised bus is sampled six cycles after the save read address is issued
`define RI_SAVE_WAIT     4'h4
// cycles the save-done flag stays high
`define RI_DONE_HOLD     4'h4
// depth of the save data fifo
`define RI_FIFO_DEPTH    4

`endif

// [hw/ram_init_pkg.sv]
package ram_init_pkg;
   // sequencer states, one bit changing per step except IADDR or IDATA to HOLD and SPUSH back to SADDR
   typedef enum logic [2:0] {
      ST_IDLE  = 3'h0,                    // waiting for init or save
      ST_IADDR = 3'h1,                    // init address presented
      ST_IDATA = 3'h3,                    // init data and strobe presented
      ST_SADDR = 3'h2,                    // save read address issued
      ST_SWAIT = 3'h6,                    // waiting for ram data to cross
      ST_SPUSH = 3'h7,                    // pushing word into fifo
      ST_DONE  = 3'h5,                    // save-done flag high
      ST_HOLD  = 3'h4                     // waiting for init done or request low
   } seq_state_t;

   typedef logic [8:0] word_t;            // one client data word
endpackage : ram_init_pkg

// [hw/save_fifo_if.sv]
`timescale 1ns/100ps
// carries the save data stream into and out of the fifo
interface save_fifo_if #(
   parameter int W = 9
);
   logic [W-1:0] push_data;               // word to store
   logic         push_valid;              // word offered
   logic         push_ready;              // fifo has room
   logic [W-1:0] pop_data;                // oldest word, registered
   logic         pop_valid;               // pop_data holds a word
   logic         pop_ready;               // consumer takes the word
   logic         empty;                   // nothing stored or staged

   modport fill (output push_data, output push_valid, input push_ready,
                 input pop_data, input pop_valid, output pop_ready, input empty);
   modport store (input push_data, input push_valid, output push_ready,
                  output pop_data, output pop_valid, input pop_ready, output empty);
endinterface : save_fifo_if

// [hw/save_fifo.sv]
`timescale 1ns/100ps
// small fifo with a registered read stage; full stalls the producer
module save_fifo #(
   parameter int W = 9,                   // word width
   parameter int D = 4                    // storage depth
) (
   input  wire logic clk_i,               // init clock
   input  wire logic rst_i,               // sync reset, active high
   save_fifo_if.store f                   // push and pop sides
);
   localparam int PW = (D > 1) ? $clog2(D) : 1;

   logic [W-1:0]  mem [D];                // storage array
   logic [PW-1:0] wp_q;                   // write pointer
   logic [PW-1:0] rp_q;                   // read pointer
   logic [PW:0]   cnt_q;                  // words in storage
   logic [W-1:0]  od_q;                   // registered read data
   logic          ov_q;                   // read register holds a word

   // pointer wrap for any depth, not only powers of two
   function automatic logic [PW-1:0] nxt(input logic [PW-1:0] p);
      nxt = (p == PW'(D - 1)) ? '0 : p + 1'b1;
   endfunction : nxt

   wire push = f.push_valid && f.push_ready;
   wire load = (cnt_q != '0) && (!ov_q || f.pop_ready);

   assign f.push_ready = (cnt_q != (PW + 1)'(D));
   assign f.pop_data   = od_q;
   assign f.pop_valid  = ov_q;
   assign f.empty      = (cnt_q == '0) && !ov_q;

   // storage writes carry no reset; pointers guard them
   always_ff @(posedge clk_i) begin
      if (push) begin
         mem[wp_q] <= f.push_data;
      end
   end

   // pointers, count and the read register
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wp_q  <= '0;
         rp_q  <= '0;
         cnt_q <= '0;
         ov_q  <= 1'b0;
         od_q  <= '0;
      end else begin
         if (push) begin
            wp_q <= nxt(wp_q);
         end
         if (load) begin
            rp_q <= nxt(rp_q);
            od_q <= mem[rp_q];
            ov_q <= 1'b1;
         end else if (f.pop_ready) begin
            ov_q <= 1'b0;
         end
         cnt_q <= cnt_q + (PW + 1)'(push) - (PW + 1)'(load);
      end
   end
endmodule : save_fifo

// [hw/ram_init_save_client_port.sv]
`timescale 1ns/100ps
`include "ram_init_regs.svh"

// Overview of operation
// R1 - one high strobe per block, low after reset
// R2 - strobes change only on init clock edges
// R3 - keep client selected until all addresses visited
// R4 - no other client selected before we finish
// R5 - client signals active only during init or save
// R6 - save ports only meaningful when save enabled
// R7 - requester holds save request low during init
// R8 - requester holds request until done, then drops
// R9 - save-done resets low, pulses several cycles
// R10 - data-available high through save, low after
// R11 - nine-bit save bus, zero after reset
// R12 - store nine or eight low bits
// R13 - init: address, then data with strobe
// R14 - save: address, ram data, then store
// R15 - shared ram clock at most 10 MHz
// R16 - ascending addresses, one word per strobe
module ram_init_save_client_port
   import ram_init_pkg::*;
#(
   parameter int NBLK    = 2,             // ram blocks in the client
   parameter int AW      = 8,             // address bits per block
   parameter bit SAVE_EN = 1'b1,          // on-demand save selected
   parameter bit DATA9   = 1'b1           // store all nine bits
) (
   input  wire logic                  clk_i,                      // init clock, 50 MHz
   input  wire logic                  rst_i,                      // flash system reset, sync high
   input  wire logic                  power_up_i,                 // power-up init request
   input  wire logic                  init_done_i,                // init complete
   input  wire ram_init_pkg::word_t   init_data_i,                // word read from flash
   input  wire logic                  init_valid_i,               // init word offered
   output logic                       init_ready_o,               // init word wanted
   input  wire logic                  save_req_i,                 // save request
   input  wire logic [NBLK-1:0]       ram_block_data_available_i, // per block data available
   input  wire logic [NBLK*9-1:0]     ram_read_data_out_i,        // per block save buses
   output logic [NBLK-1:0]            ram_block_write_strobe_o,   // per block select/write
   output logic [AW-1:0]              ram_addr_o,                 // ram address
   output ram_init_pkg::word_t        ram_wdata_o,                // init write data
   output logic                       client_active_o,            // client holds the init engine
   output logic                       save_done_o,                // save complete flag
   output ram_init_pkg::word_t        page_data_o,                // word to flash page buffer
   output logic                       page_valid_o,               // page word offered
   input  wire logic                  page_ready_i                // page buffer takes word
);
   import ram_init_pkg::*;

   // block index width; one bit even for a single block
   localparam int BW = (NBLK > 1) ? $clog2(NBLK) : 1;

   // each _d below is the next value from the comb block
   seq_state_t         st_q;             // sequencer state
   seq_state_t         st_d;
   logic [AW-1:0]      addr_q;           // current ram address
   logic [AW-1:0]      addr_d;
   logic [BW-1:0]      blk_q;            // current ram block
   logic [BW-1:0]      blk_d;
   logic [NBLK-1:0]    stb_q;            // per block strobes
   logic [NBLK-1:0]    stb_d;
   word_t              wdata_q;          // init write data
   word_t              wdata_d;
   logic               rdy_q;            // init word wanted
   logic               rdy_d;
   logic               act_q;            // client selected
   logic               act_d;
   logic               done_q;           // save-done flag
   logic               done_d;
   logic [3:0]         cnt_q;            // wait and hold counter
   logic [3:0]         cnt_d;
   logic               fin_q;            // power-up init already served
   logic               fin_d;
   logic               save_q;           // current sequence is a save
   logic               save_d;

   // three-stage capture of the save buses, which change on the ram read clock
   word_t              s1_q [NBLK];      // first stage, read only by s2
   word_t              s2_q [NBLK];
   word_t              s3_q [NBLK];

   save_fifo_if #(.W(`RI_WORD_W)) sq (); // save data path

   // next address, shared by init and save sweeps
   // wraps to zero past the top; the block step relies on it
   function automatic logic [AW-1:0] step_addr(input logic [AW-1:0] a);
      step_addr = a + AW'(1);
   endfunction : step_addr

   // one-hot select of a block
   // an index past the last block selects none
   function automatic logic [NBLK-1:0] onehot(input logic [BW-1:0] b);
      onehot = NBLK'(1) << b;
   endfunction : onehot

   // decode of the running conditions
   // fin_q stops a second init while power-up stays high
   wire init_run  = power_up_i && !init_done_i && !fin_q;                        // R5
   wire save_run  = SAVE_EN && save_req_i && init_done_i;                        // R6 R7
   wire last_addr = (addr_q == {AW{1'b1}});                                      // R16
   wire last_blk  = (blk_q == BW'(NBLK - 1));
   wire init_take = init_valid_i && rdy_q;
   // the wait covers the ram read edge and the capture stages
   wire wait_end  = (cnt_q == `RI_SAVE_WAIT);
   wire hold_end  = (cnt_q == `RI_DONE_HOLD);
   word_t sel_s2;
   word_t sel_s3;
   assign sel_s2  = s2_q[blk_q];
   assign sel_s3  = s3_q[blk_q];
   // a word counts only once the second and third stages agree
   wire bus_stable = (sel_s2 == sel_s3);                                         // R11
   // eight-bit mode keeps the low byte, bit 8 cleared
   wire word_t save_word = DATA9 ? sel_s3 : (sel_s3 & `RI_BYTE_MASK);            // R12

   // fifo sits between the ram read data and the flash page buffer
   // it lets the sweep run five words ahead of a slow page buffer, four in storage and one in the read register
   assign sq.push_data  = save_word;
   assign sq.push_valid = (st_q == ST_SPUSH) && bus_stable;
   assign sq.pop_ready  = page_ready_i;

   save_fifo #(
      .W (`RI_WORD_W),
      .D (`RI_FIFO_DEPTH)
   ) u_fifo (
      .clk_i (clk_i),
      .rst_i (rst_i),
      .f     (sq)
   );

   // sequencer next state; strobes are recomputed so each lasts one cycle
   always_comb begin
      st_d    = st_q;
      addr_d  = addr_q;
      blk_d   = blk_q;
      stb_d   = '0;
      wdata_d = wdata_q;
      rdy_d   = 1'b0;
      act_d   = act_q;
      done_d  = 1'b0;
      cnt_d   = cnt_q;
      fin_d   = fin_q;
      save_d  = save_q;
      unique case (st_q)
         ST_IDLE: begin
            // a sweep always starts at block 0, address 0
            addr_d = '0;
            blk_d  = '0;
            cnt_d  = '0;
            if (init_run) begin
               // init has priority; the save request must be low now anyway
               st_d   = ST_IADDR;                                                // R13
               act_d  = 1'b1;                                                    // R3
               save_d = 1'b0;
               rdy_d  = 1'b1;
            end else if (save_run) begin
               st_d   = ST_SADDR;                                                // R14
               act_d  = 1'b1;                                                    // R3
               save_d = 1'b1;
               stb_d  = onehot('0) & ram_block_data_available_i;                 // R10
            end
         end

         ST_IADDR: begin
            // address stands; wait for the flash word
            if (!init_run) begin
               st_d  = ST_HOLD;                                                  // R5
            end else if (init_take) begin
               st_d    = ST_IDATA;
               wdata_d = init_data_i;                                            // R13
               stb_d   = onehot(blk_q);                                          // R1 R13
            end else begin
               rdy_d = 1'b1;
            end
         end

         ST_IDATA: begin
            // ram captures on this edge; move on
            if (last_addr && last_blk) begin
               st_d  = ST_HOLD;
               fin_d = 1'b1;
               act_d = 1'b0;                                                     // R4
            end else begin
               st_d   = ST_IADDR;
               addr_d = step_addr(addr_q);                                       // R16
               blk_d  = last_addr ? blk_q + BW'(1) : blk_q;
               rdy_d  = 1'b1;
            end
         end

         ST_SADDR: begin
            // ram answers next edge, then the bus crosses three stages
            st_d  = ST_SWAIT;
            cnt_d = '0;
         end

         ST_SWAIT: begin
            // count out the read edge and the capture stages
            cnt_d = cnt_q + 4'h1;
            if (wait_end) begin
               st_d = ST_SPUSH;
            end
         end

         ST_SPUSH: begin
            // full fifo stalls the sweep here until the page buffer drains
            if (sq.push_ready && bus_stable) begin
               if (last_addr && last_blk) begin
                  st_d  = ST_DONE;
                  cnt_d = '0;
               end else begin
                  st_d   = ST_SADDR;                                             // R3
                  addr_d = step_addr(addr_q);                                    // R16
                  blk_d  = last_addr ? blk_q + BW'(1) : blk_q;
                  stb_d  = onehot(last_addr ? blk_q + BW'(1) : blk_q)
                           & ram_block_data_available_i;                         // R2
               end
            end
         end

         ST_DONE: begin
            // done only once every word has left the fifo
            if (sq.empty) begin
               done_d = 1'b1;                                                    // R9
               cnt_d  = cnt_q + 4'h1;
               // active drops with the flag, releasing the engine
               if (hold_end) begin
                  done_d = 1'b0;
                  st_d   = ST_HOLD;
                  act_d  = 1'b0;                                                 // R4
               end
            end
         end

         ST_HOLD: begin
            // wait for the requester to drop the save or for init to finish
            act_d = 1'b0;
            if (save_q ? !save_req_i : !init_run) begin                          // R8
               st_d = ST_IDLE;
            end
         end

         default: begin
            st_d  = ST_IDLE;
            act_d = 1'b0;
         end
      endcase
   end

   // sequencer registers; all outputs but the page word and page valid come straight from these
   // everything resets here, so a cut sweep leaves nothing behind
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st_q    <= ST_IDLE;
         addr_q  <= '0;
         blk_q   <= '0;
         stb_q   <= '0;                                                          // R1
         wdata_q <= `RI_WORD_RESET;
         rdy_q   <= 1'b0;
         act_q   <= 1'b0;
         done_q  <= 1'b0;                                                        // R9
         cnt_q   <= '0;
         fin_q   <= 1'b0;
         save_q  <= 1'b0;
      end else begin
         st_q    <= st_d;
         addr_q  <= addr_d;
         blk_q   <= blk_d;
         stb_q   <= stb_d;                                                       // R2
         wdata_q <= wdata_d;
         rdy_q   <= rdy_d;
         act_q   <= act_d;
         done_q  <= done_d;
         cnt_q   <= cnt_d;
         fin_q   <= fin_d;
         save_q  <= save_d;
      end
   end

   // save bus capture; reset value stands for the bus after reset
   // limitation: the bus must hold a word for two init clocks
   always_ff @(posedge clk_i) begin
      for (int b = 0; b < NBLK; b++) begin
         if (rst_i) begin
            s1_q[b] <= `RI_WORD_RESET;                                           // R11
            s2_q[b] <= `RI_WORD_RESET;
            s3_q[b] <= `RI_WORD_RESET;
         end else begin
            s1_q[b] <= ram_read_data_out_i[b*`RI_WORD_W +: `RI_WORD_W];
            s2_q[b] <= s1_q[b];
            s3_q[b] <= s2_q[b];
         end
      end
   end

   // outputs
   assign ram_block_write_strobe_o = stb_q;
   assign ram_addr_o               = addr_q;
   assign ram_wdata_o              = wdata_q;
   assign init_ready_o             = rdy_q;
   assign client_active_o          = act_q;
   assign save_done_o              = done_q;
   assign page_data_o              = sq.pop_data;
   assign page_valid_o             = sq.pop_valid;
endmodule : ram_init_save_client_port

// [dv/ram_init_client_properties.sv]
`timescale 1ns/100ps
// pin level checks for the ram client port, watching top level ports only
module ram_init_client_properties
   import ram_init_pkg::*;
#(
   parameter int NBLK  = 2,                                 // ram blocks
   parameter int AW    = 8,                                 // address bits per block
   parameter bit DATA9 = 1'b1                               // nine-bit storage
) (
   input  wire logic                clk_i,                      // init clock
   input  wire logic                rst_i,                      // sync reset
   input  wire logic                power_up_i,                 // power-up request
   input  wire logic                init_done_i,                // init complete
   input  wire ram_init_pkg::word_t init_data_i,                // flash word
   input  wire logic                init_valid_i,               // flash word offered
   input  wire logic                init_ready_o,               // flash word wanted
   input  wire logic                save_req_i,                 // save request
   input  wire logic [NBLK-1:0]     ram_block_data_available_i, // per block available
   input  wire logic [NBLK-1:0]     ram_block_write_strobe_o,   // per block strobe
   input  wire logic [AW-1:0]       ram_addr_o,                 // ram address
   input  wire ram_init_pkg::word_t ram_wdata_o,                // init write data
   input  wire logic                client_active_o,            // client selected
   input  wire logic                save_done_o,                // save complete flag
   input  wire ram_init_pkg::word_t page_data_o,                // page word
   input  wire logic                page_valid_o,               // page word offered
   input  wire logic                page_ready_i                // page word taken
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   wire any_stb  = |ram_block_write_strobe_o;                // some block strobed
   wire init_run = power_up_i && !init_done_i;               // power-up window open

   strobe_onehot_a: assert property ($onehot0(ram_block_write_strobe_o))
      else $error("more than one block strobe high");
   strobe_pulse_a: assert property (any_stb |=> !any_stb)
      else $error("block strobe longer than one cycle");
   strobe_selected_a: assert property (any_stb |-> client_active_o)
      else $error("strobe outside the client sweep");
   active_cause_a: assert property (client_active_o |-> init_run || save_req_i)
      else $error("client active without init or save");
   init_write_a: assert property (init_run && init_ready_o && init_valid_i |=>
      any_stb && ram_wdata_o == $past(init_data_i) && $stable(ram_addr_o))
      else $error("init word not written at its address");
   addr_step_a: assert property (client_active_o && $past(client_active_o) && $changed(ram_addr_o)
      |-> ram_addr_o == AW'($past(ram_addr_o) + 1))
      else $error("address did not step by one");
   done_len_a: assert property ($rose(save_done_o) |-> save_done_o [*4] ##1 !save_done_o)
      else $error("save done not high for four cycles");
   done_end_a: assert property ($rose(save_done_o) |-> client_active_o && !any_stb
      && !page_valid_o && save_req_i)
      else $error("save done while still sweeping");
   save_avail_a: assert property (any_stb && !init_run
      |-> (ram_block_write_strobe_o & ~ram_block_data_available_i) == '0)
      else $error("save strobe on a block without data");
   page_hold_a: assert property (page_valid_o && !page_ready_i |=> page_valid_o && $stable(page_data_o))
      else $error("page word dropped while stalled");
   page_width_a: assert property (page_valid_o |-> DATA9 || !page_data_o[8])
      else $error("top bit stored in eight-bit mode");

   cover property (init_run && any_stb);
   cover property ($rose(save_done_o));
   cover property (page_valid_o && !page_ready_i);
endmodule : ram_init_client_properties

bind ram_init_save_client_port ram_init_client_properties #(.NBLK(NBLK), .AW(AW), .DATA9(DATA9)) i_props (
   .clk_i(clk_i), .rst_i(rst_i), .power_up_i(power_up_i), .init_done_i(init_done_i),
   .init_data_i(init_data_i), .init_valid_i(init_valid_i), .init_ready_o(init_ready_o),
   .save_req_i(save_req_i), .ram_block_data_available_i(ram_block_data_available_i),
   .ram_block_write_strobe_o(ram_block_write_strobe_o), .ram_addr_o(ram_addr_o),
   .ram_wdata_o(ram_wdata_o), .client_active_o(client_active_o), .save_done_o(save_done_o),
   .page_data_o(page_data_o), .page_valid_o(page_valid_o), .page_ready_i(page_ready_i));

// [dv/ram_model.sv]
`timescale 1ns/100ps
// behavioural ram blocks: init strobes write, save strobes read
module ram_model #(
   parameter int NBLK = 2,                      // blocks modelled
   parameter int AW   = 3                       // address bits per block
) (
   input  wire logic            clk_i,          // shared ram clock
   input  wire logic            rst_i,          // flash system reset
   input  wire logic            rd_i,           // save running, strobes read
   input  wire logic [NBLK-1:0] cs_i,           // per block select
   input  wire logic [AW-1:0]   addr_i,         // word address
   input  wire logic [8:0]      wdata_i,        // init write data
   output logic [NBLK*9-1:0]    dout_o          // per block read buses
);
   logic [8:0] mem [NBLK][2**AW];               // contents, user logic may poke them

   // plain always so the bench can also write contents between flows
   always @(posedge clk_i) begin
      if (rst_i) begin
         dout_o <= '0;
      end
      for (int b = 0; b < NBLK; b++) begin
         if (cs_i[b] && !rd_i) mem[b][addr_i] <= wdata_i;
         if (cs_i[b] && rd_i && !rst_i) dout_o[b*9+:9] <= mem[b][addr_i];
      end
   end
endmodule : ram_model

// [dv/tb.sv]
`timescale 1ns/100ps
module tb;
   import ram_init_pkg::*;
   localparam int NBLK = 2;                  // two ram blocks
   localparam int AW   = 3;                  // short blocks keep the run brief
   localparam int NA   = 2**AW;              // words per block
   localparam int NW   = NBLK*NA;            // words in the client space
   typedef struct packed {
      word_t iw;                             // word loaded at power-up
      word_t sw;                             // word left by the user for the save
   } row_t;
   logic              clk_i, rst_i, power_up_i, init_done_i, init_valid_i, save_req_i, page_ready_i;
   word_t             init_data_i, wdata, page_data, page_data8;
   logic [NBLK-1:0]   avail, strobe;
   logic [NBLK*9-1:0] ram_dout;
   logic [AW-1:0]     addr;
   logic              init_ready, active, done, page_valid;
   row_t              rows [NW];
   int                failures, cmp_count, widx, nstrobe, cycles, i, k;

   ram_init_save_client_port #(.NBLK(NBLK), .AW(AW), .SAVE_EN(1'b1), .DATA9(1'b1))
   i_ram_init_save_client_port (.clk_i(clk_i), .rst_i(rst_i), .power_up_i(power_up_i),
      .init_done_i(init_done_i), .init_data_i(init_data_i), .init_valid_i(init_valid_i),
      .init_ready_o(init_ready), .save_req_i(save_req_i), .ram_block_data_available_i(avail),
      .ram_read_data_out_i(ram_dout), .ram_block_write_strobe_o(strobe), .ram_addr_o(addr),
      .ram_wdata_o(wdata), .client_active_o(active), .save_done_o(done),
      .page_data_o(page_data), .page_valid_o(page_valid), .page_ready_i(page_ready_i));
   ram_model #(.NBLK(NBLK), .AW(AW)) i_ram_model (.clk_i(clk_i), .rst_i(rst_i), .rd_i(save_req_i),
      .cs_i(strobe), .addr_i(addr), .wdata_i(wdata), .dout_o(ram_dout));
   // eight-bit twin on the same stimulus; only its page word is compared
   ram_init_save_client_port #(.NBLK(NBLK), .AW(AW), .SAVE_EN(1'b1), .DATA9(1'b0))
   i_ram_init_save_client_port_b8 (.clk_i(clk_i), .rst_i(rst_i), .power_up_i(power_up_i),
      .init_done_i(init_done_i), .init_data_i(init_data_i), .init_valid_i(init_valid_i),
      .init_ready_o(), .save_req_i(save_req_i), .ram_block_data_available_i(avail),
      .ram_read_data_out_i(ram_dout), .ram_block_write_strobe_o(), .ram_addr_o(),
      .ram_wdata_o(), .client_active_o(), .save_done_o(), .page_data_o(page_data8),
      .page_valid_o(), .page_ready_i(page_ready_i));

   initial begin
      clk_i = 1'b0;
      forever #10 clk_i = ~clk_i;            // 50 MHz
   end

   task automatic tick(input int n);
      repeat (n) @(posedge clk_i);
      #1;                                    // inputs move just after the edge
   endtask : tick

   task automatic chk(input logic [8:0] got, input logic [8:0] exp);
      cmp_count++;
      if (got !== exp) begin
         failures++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task automatic report_and_stop;
      $display("comparisons %0d mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : report_and_stop

   // flash side feeder, strobe counter and hang guard share one edge process
   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 5000) begin
         failures++;
         report_and_stop();
      end
      if (|strobe) nstrobe++;
      if (init_ready && init_valid_i) widx++;
      #1 init_data_i = rows[widx % NW].iw;   // next word only after a handshake
   end

   initial begin
      for (i = 0; i < NW; i++) begin
         rows[i].iw = 9'(9'h0A5 + i*9'h03B);
         rows[i].sw = ~rows[i].iw;
      end
      rows[0].sw = 9'h100;                   // lone top bit
      rows[NW-1].sw = 9'h1FF;                // all bits set
      {rst_i, power_up_i, init_done_i, init_valid_i} = 4'h9;
      {save_req_i, avail, page_ready_i} = '0;
      {failures, cmp_count} = '0;
      tick(6);
      chk(9'(strobe), 9'h000);
      chk(9'(done), 9'h000);
      rst_i = 1'b0;
      power_up_i = 1'b1;
      k = 0;
      while (active !== 1'b1 && k < 20) begin tick(1); k++; end
      k = 0;
      while (active !== 1'b0 && k < 200) begin tick(1); k++; end
      chk(9'(widx), 9'(NW));
      tick(1);
      init_done_i = 1'b1;
      tick(2);
      for (i = 0; i < NW; i++) begin
         chk(i_ram_model.mem[i/NA][i%NA], rows[i].iw);
         i_ram_model.mem[i/NA][i%NA] = rows[i].sw;
      end
      $display("power-up init test done");

      save_req_i = 1'b1;
      avail = '1;
      tick(80);
      k = nstrobe;
      tick(20);
      chk(9'(nstrobe - k), 9'h000);
      chk(9'(page_valid), 9'h001);
      page_ready_i = 1'b1;
      for (i = 0; i < NW; i++) begin
         k = 0;
         while (page_valid !== 1'b1 && k < 50) begin tick(1); k++; end
         chk(page_data, rows[i].sw);
         chk(page_data8, rows[i].sw & 9'h0FF);
         tick(1);
      end
      k = 0;
      while (done !== 1'b1 && k < 200) begin tick(1); k++; end
      chk({7'h00, active, page_valid}, 9'h002);
      tick(3);
      chk(9'(done), 9'h001);
      tick(1);
      chk(9'(done), 9'h000);
      save_req_i = 1'b0;
      avail = '0;
      tick(3);
      chk(9'(active), 9'h000);
      $display("save with stalled page buffer test done");

      save_req_i = 1'b1;
      avail = '1;
      tick(12);
      chk(9'(active), 9'h001);
      rst_i = 1'b1;
      tick(2);
      chk({5'h00, strobe, done, active}, 9'h000);
      chk(9'(page_valid), 9'h000);
      rst_i = 1'b0;
      save_req_i = 1'b0;
      avail = '0;
      k = nstrobe;
      tick(10);
      chk({8'h00, active}, 9'(nstrobe - k));
      $display("reset in mid save test done");
      report_and_stop();
   end
endmodule : tb
